/* File: rtl/tsa_consts.vh */
// tsa_consts.vh: constants of the temperature sensor alarm slave
// assumes: included by bare name from the design files under rtl/
`ifndef TSA_CONSTS_VH
`define TSA_CONSTS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TSA_CLK_KHZ 100000
`define TSA_CONV_MS 75
`define TSA_CONV_MAX_MS 125
`define TSA_BUS_STALL_TIMEOUT_MS 25
`define TSA_BUS_STALL_TIMEOUT_MAX_MS 35

// ----------------------------------------------------------------
// bus address and frame
// ----------------------------------------------------------------
`define TSA_DEV_ID 4'h3
`define TSA_BIT_ACK 4'h8
`define TSA_BIT_END 4'h9

// ----------------------------------------------------------------
// register pointers
// ----------------------------------------------------------------
`define TSA_PTR_CFG 8'h01
`define TSA_PTR_UPPER 8'h02
`define TSA_PTR_LOWER 8'h03
`define TSA_PTR_CRIT 8'h04
`define TSA_PTR_TEMP 8'h05
`define TSA_PTR_SMB 8'h22

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define TSA_CFG_INTMODE 0
`define TSA_CFG_CRITONLY 2
`define TSA_CFG_CLEAR 5
`define TSA_CFG_SHDN 8
`define TSA_CFG_HYST_HI 11
`define TSA_CFG_HYST_LO 9
`define TSA_SMB_BUS_STALL_TIMEOUT_EN 7
`define TSA_CFG_WMASK 16'h0F05
`define TSA_SMB_WMASK 16'h0080
`define TSA_REG_RST 16'h0000
`define TSA_TEMP_RST 11'h000
`define TSA_SYNC_RST 16'hC000

// hysteresis codes and widths in 0.125 degree steps
`define TSA_HYST_OFF 3'h0
`define TSA_HYST_0 3'h1
`define TSA_HYST_1P5 3'h2
`define TSA_HYST_3 3'h3
`define TSA_HYST_6 3'h4
`define TSA_HW_0 13'h0000
`define TSA_HW_1P5 13'h000C
`define TSA_HW_3 13'h0018
`define TSA_HW_6 13'h0030

`endif

/* File: rtl/tsa_top.v */
// tsa_top.v: temperature sensor with limit alarm and two-wire slave port
// assumes: scl, sda, address selects and converter word arrive from
// outside the clk_sys domain; pads resolve sda and alert from the enables
//
// Behaviour
// - temperature is an 11-bit word, one step per 0.125 degree
// - temperature register refreshed at least 8 times per second
// - each conversion lasts 75 ms, never over 125 ms, then latches
// - result word spans -20 to +125 degrees
// - upper, lower and critical limits writable over the serial port
// - in comparator mode alert asserts when the result is above the upper limit
// - alert is active low open drain, only ever pulled low
// - alert modes: latched interrupt, critical only, comparator
// - hysteresis selectable: off, 0, 1.5, 3 or 6 degrees
// - shutdown stops conversion and freezes the alarm flags, serial port keeps working
// - data sampled on scl rise, changed after scl fall
// - sda only ever driven low
// - three address select pins form part of the bus address
// - an open address select pin counts as zero
// - enabled bus timeout expires between 25 and 35 ms
// - address byte: 0011, three select bits, read when last bit set
// - each received byte acknowledged by driving sda low on ninth clock, except an address byte that does not match
// - enabled timeout resets the serial port when scl stays low
// - interrupt alert holds until software writes one to clear bit
`timescale 1ns/1ns
`include "tsa_consts.vh"

module tsa_top #(
  parameter integer CONV_CYCLES = `TSA_CONV_MS * `TSA_CLK_KHZ,
  parameter integer BUS_STALL_TIMEOUT_CYCLES = `TSA_BUS_STALL_TIMEOUT_MS * `TSA_CLK_KHZ
) (
  input wire clk_sys,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  input wire addr_select_bit0,
  input wire addr_select_bit1,
  input wire addr_select_bit2,
  input wire [10:0] temp_adc_in,
  output reg alert_out,
  output reg alert_oe_n,
  output reg conv_busy
);

  localparam [23:0] CONV_LAST = CONV_CYCLES[23:0] - 24'h1;
  localparam [23:0] BUS_STALL_TIMEOUT_LAST = BUS_STALL_TIMEOUT_CYCLES[23:0] - 24'h1;

  // serial port states
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_RX = 3'h2;
  localparam [2:0] S_TX = 3'h3;
  localparam [2:0] S_NACK = 3'h4;

  // --------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------
  reg [15:0] sync_a;
  reg [15:0] sync_b;
  reg scl_d;
  reg sda_d;

  // two flops for every pin and converter bit
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_a <= `TSA_SYNC_RST; // scl and sda idle high, no false edge
      sync_b <= `TSA_SYNC_RST;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync_a <= {scl_in, sda_in, addr_select_bit2, addr_select_bit1,
                 addr_select_bit0, temp_adc_in};
      sync_b <= sync_a;
      scl_d <= sync_b[15];
      sda_d <= sync_b[14];
    end
  end

  wire scl_s = sync_b[15];
  wire sda_s = sync_b[14];
  // open select pins are pulled down at the pad, so they read zero
  wire [2:0] addr_sel = sync_b[13:11];
  wire [10:0] adc_s = sync_b[10:0];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  reg [15:0] cfg;
  reg [15:0] smb;
  reg [10:0] upper;
  reg [10:0] lower;
  reg [10:0] crit;
  reg [10:0] temp;
  reg above_upper;
  reg below_lower;
  reg above_crit;
  reg int_latch;
  reg conv_tick;
  reg [23:0] conv_cnt;

  wire shdn = cfg[`TSA_CFG_SHDN];
  wire [2:0] hyst_sel = cfg[`TSA_CFG_HYST_HI:`TSA_CFG_HYST_LO];
  wire [15:0] temp_word = {above_crit, above_upper, below_lower,
                           {2{temp[10]}}, temp};

  // write strobe from the serial port
  reg wr_stb;
  reg [7:0] ptr;
  reg [15:0] wr_data;
  wire clear_req = wr_stb & (ptr == `TSA_PTR_CFG) &
                   wr_data[`TSA_CFG_CLEAR];

  // --------------------------------------------------------------
  // conversion timebase
  // --------------------------------------------------------------
  // one result per 75 ms, well inside the 125 ms bound
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conv_cnt <= 24'h000000;
      conv_tick <= 1'b0;
      conv_busy <= 1'b0;
      temp <= `TSA_TEMP_RST;
    end else begin
      conv_tick <= 1'b0;
      conv_busy <= ~shdn;
      if (shdn) begin
        conv_cnt <= 24'h000000;
      end else if (conv_cnt == CONV_LAST) begin
        conv_cnt <= 24'h000000;
        temp <= adc_s;
        conv_tick <= 1'b1;
      end else begin
        conv_cnt <= conv_cnt + 24'h000001;
      end
    end
  end

  // --------------------------------------------------------------
  // limit compare with hysteresis
  // --------------------------------------------------------------
  reg [12:0] hyst_w;

  // hysteresis width in 0.125 degree steps
  always @* begin
    case (hyst_sel)
      `TSA_HYST_1P5: hyst_w = `TSA_HW_1P5;
      `TSA_HYST_3: hyst_w = `TSA_HW_3;
      `TSA_HYST_6: hyst_w = `TSA_HW_6;
      default: hyst_w = `TSA_HW_0;
    endcase
  end

  wire signed [12:0] t_s = {{2{temp[10]}}, temp};
  wire signed [12:0] up_s = {{2{upper[10]}}, upper};
  wire signed [12:0] lo_s = {{2{lower[10]}}, lower};
  wire signed [12:0] cr_s = {{2{crit[10]}}, crit};
  wire signed [12:0] hw_s = hyst_w;
  wire next_upper = above_upper ? (t_s > up_s - hw_s) : (t_s > up_s);
  wire next_lower = below_lower ? (t_s < lo_s + hw_s) : (t_s < lo_s);
  wire next_crit = above_crit ? (t_s > cr_s - hw_s) : (t_s > cr_s);
  wire window_edge = (next_upper != above_upper) |
                     (next_lower != below_lower);

  // flags move once per new result; the interrupt latch sets when a result moves the upper or lower flag and clears on a clear write
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      above_upper <= 1'b0;
      below_lower <= 1'b0;
      above_crit <= 1'b0;
      int_latch <= 1'b0;
    end else begin
      if (conv_tick) begin
        above_upper <= next_upper;
        below_lower <= next_lower;
        above_crit <= next_crit;
      end
      // a new event wins over a clear in the same cycle
      if (conv_tick & window_edge)
        int_latch <= 1'b1;
      else if (clear_req)
        int_latch <= 1'b0;
    end
  end

  // alert pin: only ever pulled low
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alert_out <= 1'b0;
      alert_oe_n <= 1'b1;
    end else begin
      alert_out <= 1'b0;
      if (cfg[`TSA_CFG_CRITONLY])
        alert_oe_n <= ~above_crit;
      else if (cfg[`TSA_CFG_INTMODE])
        alert_oe_n <= ~(int_latch | above_crit);
      else
        alert_oe_n <= ~(above_upper | below_lower | above_crit);
    end
  end

  // --------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg <= `TSA_REG_RST;
      smb <= `TSA_REG_RST;
      upper <= `TSA_TEMP_RST;
      lower <= `TSA_TEMP_RST;
      crit <= `TSA_TEMP_RST;
    end else if (wr_stb) begin
      case (ptr)
        `TSA_PTR_CFG: cfg <= wr_data & `TSA_CFG_WMASK;
        `TSA_PTR_SMB: smb <= wr_data & `TSA_SMB_WMASK;
        `TSA_PTR_UPPER: upper <= wr_data[10:0];
        `TSA_PTR_LOWER: lower <= wr_data[10:0];
        `TSA_PTR_CRIT: crit <= wr_data[10:0];
        default: ;
      endcase
    end
  end

  reg [15:0] rd_mux;

  // read view of the selected register
  always @* begin
    case (ptr)
      `TSA_PTR_CFG: rd_mux = cfg;
      `TSA_PTR_SMB: rd_mux = smb;
      `TSA_PTR_UPPER: rd_mux = {{5{upper[10]}}, upper};
      `TSA_PTR_LOWER: rd_mux = {{5{lower[10]}}, lower};
      `TSA_PTR_CRIT: rd_mux = {{5{crit[10]}}, crit};
      `TSA_PTR_TEMP: rd_mux = temp_word;
      default: rd_mux = `TSA_REG_RST;
    endcase
  end

  // --------------------------------------------------------------
  // bus stall timeout
  // --------------------------------------------------------------
  reg [23:0] bus_stall_timeout_cnt;
  reg bus_stall_timeout_hit;
  reg [2:0] st;

  // counts scl low time during a frame
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_stall_timeout_cnt <= 24'h000000;
      bus_stall_timeout_hit <= 1'b0;
    end else begin
      bus_stall_timeout_hit <= 1'b0;
      if (scl_s | (st == S_IDLE) | ~smb[`TSA_SMB_BUS_STALL_TIMEOUT_EN]) begin
        bus_stall_timeout_cnt <= 24'h000000;
      end else if (bus_stall_timeout_cnt == BUS_STALL_TIMEOUT_LAST) begin
        bus_stall_timeout_cnt <= 24'h000000;
        bus_stall_timeout_hit <= 1'b1;
      end else begin
        bus_stall_timeout_cnt <= bus_stall_timeout_cnt + 24'h000001;
      end
    end
  end

  // --------------------------------------------------------------
  // two-wire slave
  // --------------------------------------------------------------
  reg [3:0] bit_cnt;
  reg [7:0] shift_in;
  reg [15:0] tx_word;
  reg tx_sel;
  reg [1:0] rx_idx;
  reg [7:0] wr_hi;
  wire [7:0] tx_byte = tx_sel ? tx_word[7:0] : tx_word[15:8];

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= S_IDLE;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      tx_word <= `TSA_REG_RST;
      tx_sel <= 1'b0;
      rx_idx <= 2'h0;
      wr_hi <= 8'h00;
      ptr <= 8'h00;
      wr_data <= `TSA_REG_RST;
      wr_stb <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      wr_stb <= 1'b0;
      sda_out <= 1'b0;
      if (bus_stall_timeout_hit | stop_cond) begin
        st <= S_IDLE;
        sda_oe_n <= 1'b1;
      end else if (start_cond) begin
        st <= S_ADDR;
        bit_cnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (scl_rise & (st != S_IDLE)) begin
        if (bit_cnt < `TSA_BIT_ACK)
          shift_in <= {shift_in[6:0], sda_s};
        else if ((st == S_TX) & sda_s)
          st <= S_NACK;
        bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_fall & (st != S_IDLE)) begin
        if (bit_cnt == `TSA_BIT_ACK) begin
          sda_oe_n <= 1'b1;
          case (st)
            S_ADDR: begin
              if (shift_in[7:1] == {`TSA_DEV_ID, addr_sel}) begin
                sda_oe_n <= 1'b0;
                st <= shift_in[0] ? S_TX : S_RX;
                tx_sel <= 1'b0;
                tx_word <= rd_mux;
                rx_idx <= 2'h0;
              end else begin
                st <= S_IDLE;
              end
            end
            S_RX: begin
              sda_oe_n <= 1'b0;
              if (rx_idx == 2'h0) begin
                ptr <= shift_in;
                rx_idx <= 2'h1;
              end else if (rx_idx == 2'h1) begin
                wr_hi <= shift_in;
                rx_idx <= 2'h2;
              end else begin
                wr_data <= {wr_hi, shift_in};
                wr_stb <= 1'b1;
                rx_idx <= 2'h1;
              end
            end
            S_TX: begin
              tx_sel <= ~tx_sel;
              if (tx_sel)
                tx_word <= rd_mux;
            end
            default: ;
          endcase
        end else if (bit_cnt == `TSA_BIT_END) begin
          bit_cnt <= 4'h0;
          sda_oe_n <= 1'b1;
          if (st == S_TX)
            sda_oe_n <= tx_byte[7];
          else if (st == S_NACK)
            st <= S_IDLE;
        end else if (st == S_TX) begin
          sda_oe_n <= tx_byte[3'h7 - bit_cnt[2:0]];
        end
      end
    end
  end

endmodule // tsa_top

/* File: test/tsa_top_asserts.sv */
// tsa_top_asserts.sv: port checks for the temperature alarm slave
// assumes: bound to tsa_top; bench stalls scl only with timeout enabled
`timescale 1ns/1ns
module tsa_top_asserts #(
  parameter integer CONV_CYCLES = 200,
  parameter integer BUS_STALL_TIMEOUT_CYCLES = 500
) (
  input wire clk_sys,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire addr_select_bit0,
  input wire addr_select_bit1,
  input wire addr_select_bit2,
  input wire [10:0] temp_adc_in,
  input wire alert_out,
  input wire alert_oe_n,
  input wire conv_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // scl low run length
  // ----------------------------------------------------------------
  integer low_run;
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      low_run <= 0;
    else if (scl_in)
      low_run <= 0;
    else if (low_run < BUS_STALL_TIMEOUT_CYCLES + 20)
      low_run <= low_run + 1;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sda_low_only_a:
    assert property (sda_out == 1'b0) else $error("sda value not low");
  alert_low_only_a:
    assert property (alert_out == 1'b0) else $error("alert value not low");
  sda_edge_timing_a:
    assert property (!$stable(sda_oe_n) |-> !scl_in && !$past(scl_in))
    else $error("sda moved while scl high");
  ack_bounded_a:
    assert property ($fell(sda_oe_n) |-> ##[1:1000] sda_oe_n)
    else $error("sda held too long");
  stall_release_a:
    assert property (low_run > BUS_STALL_TIMEOUT_CYCLES + 16 |-> sda_oe_n)
    else $error("sda held after stall");
  busy_after_reset_a:
    assert property ($fell(rst) |-> ##[0:2] conv_busy)
    else $error("conversion not started");
  alert_needs_conv_a:
    assert property ($fell(alert_oe_n) |-> $past(conv_busy, 2))
    else $error("alert raised while idle");
  reset_quiet_a:
    assert property (disable iff (1'b0)
      rst |-> sda_oe_n && alert_oe_n && !conv_busy)
    else $error("outputs active in reset");
endmodule // tsa_top_asserts

bind tsa_top tsa_top_asserts #(
  .CONV_CYCLES(CONV_CYCLES),
  .BUS_STALL_TIMEOUT_CYCLES(BUS_STALL_TIMEOUT_CYCLES)
) chk (
  .clk_sys(clk_sys), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .addr_select_bit0(addr_select_bit0), .addr_select_bit1(addr_select_bit1),
  .addr_select_bit2(addr_select_bit2), .temp_adc_in(temp_adc_in),
  .alert_out(alert_out), .alert_oe_n(alert_oe_n), .conv_busy(conv_busy)
);

/* File: test/tsa_host_model.sv */
// tsa_host_model.sv: two-wire bus host, scl period 16 clk_sys cycles
// assumes: bench resolves sda_wire with a pull-up; 1 on sda_rel releases
`timescale 1ns/1ns
module tsa_host_model (
  input wire clk_sys,
  input wire sda_wire,
  output reg scl,
  output reg sda_rel
);
  // idle bus
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task w(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one bit; data moves only while scl low
  task bit_io(input logic b, output logic r);
    w(4);
    sda_rel <= b;
    w(4);
    scl <= 1'b1;
    w(4);
    r = sda_wire;
    w(4);
    scl <= 1'b0;
  endtask
  // start or repeated start
  task start;
    w(4);
    sda_rel <= 1'b1;
    w(4);
    scl <= 1'b1;
    w(8);
    sda_rel <= 1'b0;
    w(8);
    scl <= 1'b0;
  endtask
  task stop;
    w(4);
    sda_rel <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(8);
    sda_rel <= 1'b1;
    w(8);
  endtask
  // byte out or in, msb first, then the ninth bit
  task xfer(input [7:0] d, input logic nine, output [7:0] q,
            output logic acked);
    integer i;
    logic r;
    for (i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(nine, r);
    acked = !r;
  endtask
  task write_word(input [2:0] dev, input [7:0] p, input [15:0] v,
                  output logic ok);
    logic [7:0] q;
    logic a, b, c, d;
    start;
    xfer({4'h3, dev, 1'b0}, 1'b1, q, a);
    xfer(p, 1'b1, q, b);
    xfer(v[15:8], 1'b1, q, c);
    xfer(v[7:0], 1'b1, q, d);
    stop;
    ok = a & b & c & d;
  endtask
  task read_word(input [2:0] dev, input [7:0] p, output [15:0] v,
                 output logic ok);
    logic a, b, c, n;
    start;
    xfer({4'h3, dev, 1'b0}, 1'b1, v[7:0], a);
    xfer(p, 1'b1, v[7:0], b);
    start;
    xfer({4'h3, dev, 1'b1}, 1'b1, v[7:0], c);
    xfer(8'hFF, 1'b0, v[15:8], n);
    xfer(8'hFF, 1'b1, v[7:0], n);
    stop;
    ok = a & b & c;
  endtask
endmodule // tsa_host_model

/* File: test/tb_temp_sensor_alarm_serial_slave.sv */
// tb_temp_sensor_alarm_serial_slave.sv: register and alarm tests
// assumes: host model drives the bus; sda and alert have pull-ups
`timescale 1ns/1ns
`include "tsa_consts.vh"
module tb_temp_sensor_alarm_serial_slave;
  reg clk_sys;
  reg rst;
  reg [2:0] sel;
  reg [10:0] temp;
  reg [15:0] v;
  reg ok;
  reg r;
  integer i;
  integer bad_count = 0;
  integer samples_checked = 0;
  wire scl, sda_rel, sda_out, sda_oe_n, alert_out, alert_oe_n, conv_busy;
  wire sda_wire = sda_rel & (sda_oe_n | sda_out);
  tsa_top #(.CONV_CYCLES(200), .BUS_STALL_TIMEOUT_CYCLES(500)) dut (
    .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_bit0(sel[0]),
    .addr_select_bit1(sel[1]), .addr_select_bit2(sel[2]),
    .temp_adc_in(temp), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
    .conv_busy(conv_busy));
  tsa_host_model host (.clk_sys(clk_sys), .sda_wire(sda_wire),
    .scl(scl), .sda_rel(sda_rel));
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task check(input [15:0] seen, input [15:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task bit1(input logic seen, input logic exp);
    check({15'h0, seen}, {15'h0, exp});
  endtask
  task wr(input [7:0] p, input [15:0] d);
    host.write_word(sel, p, d, ok);
    bit1(ok, 1'b1);
  endtask
  task rd(input [7:0] p, input [15:0] exp);
    host.read_word(sel, p, v, ok);
    bit1(ok, 1'b1);
    check(v, exp);
  endtask
  // new temperature, then two and a quarter conversion periods
  task heat(input [10:0] t);
    temp <= t;
    repeat (450) @(posedge clk_sys);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    sel = 3'h5;
    temp = 11'h0C8;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    bit1(conv_busy, 1'b1);
    wr(`TSA_PTR_UPPER, 16'h00A0);
    wr(`TSA_PTR_LOWER, 16'h07F0);
    wr(`TSA_PTR_CRIT, 16'h0190);
    rd(`TSA_PTR_UPPER, 16'h00A0);
    rd(`TSA_PTR_LOWER, 16'hFFF0);
    rd(`TSA_PTR_CRIT, 16'h0190);
    $display("test limits done");
    heat(11'h0C8);
    rd(`TSA_PTR_TEMP, 16'h40C8);
    bit1(alert_oe_n, 1'b0);
    heat(11'h064);
    rd(`TSA_PTR_TEMP, 16'h0064);
    bit1(alert_oe_n, 1'b1);
    heat(11'h7E0);
    rd(`TSA_PTR_TEMP, 16'h3FE0);
    bit1(alert_oe_n, 1'b0);
    heat(11'h064);
    $display("test comparator done");
    wr(`TSA_PTR_CFG, 16'h0021);
    bit1(alert_oe_n, 1'b1);
    heat(11'h0C8);
    bit1(alert_oe_n, 1'b0);
    heat(11'h064);
    bit1(alert_oe_n, 1'b0);
    wr(`TSA_PTR_CFG, 16'h0021);
    repeat (4) @(posedge clk_sys);
    bit1(alert_oe_n, 1'b1);
    $display("test interrupt done");
    wr(`TSA_PTR_CFG, 16'h0804);
    heat(11'h0C8);
    bit1(alert_oe_n, 1'b1);
    heat(11'h1A0);
    bit1(alert_oe_n, 1'b0);
    rd(`TSA_PTR_TEMP, 16'hC1A0);
    heat(11'h170);
    bit1(alert_oe_n, 1'b0);
    heat(11'h150);
    bit1(alert_oe_n, 1'b1);
    wr(`TSA_PTR_CFG, 16'h0604);
    heat(11'h1A0);
    bit1(alert_oe_n, 1'b0);
    heat(11'h180);
    bit1(alert_oe_n, 1'b0);
    heat(11'h170);
    bit1(alert_oe_n, 1'b1);
    $display("test critical done");
    wr(`TSA_PTR_CFG, 16'h0100);
    repeat (4) @(posedge clk_sys);
    bit1(conv_busy, 1'b0);
    heat(11'h0C8);
    rd(`TSA_PTR_TEMP, 16'h4170);
    host.write_word(3'h4, `TSA_PTR_CFG, 16'h0000, ok);
    bit1(ok, 1'b0);
    rd(`TSA_PTR_CFG, 16'h0100);
    $display("test shutdown done");
    wr(`TSA_PTR_SMB, 16'h0080);
    host.start;
    v = {8'h00, 4'h3, sel, 1'b0};
    for (i = 7; i >= 0; i--)
      host.bit_io(v[i], r);
    repeat (8) @(posedge clk_sys);
    bit1(sda_oe_n, 1'b0);
    repeat (400) @(posedge clk_sys);
    bit1(sda_oe_n, 1'b0);
    repeat (208) @(posedge clk_sys);
    bit1(sda_oe_n, 1'b1);
    host.stop;
    rd(`TSA_PTR_SMB, 16'h0080);
    $display("test timeout done");
    report_and_stop;
  end
  // watchdog
  initial begin
    repeat (80000) @(posedge clk_sys);
    bad_count = bad_count + 1;
    report_and_stop;
  end
endmodule // tb_temp_sensor_alarm_serial_slave
